// ==== inc/hbp_pkg.sv ====
// Purpose: Shared constants for the buffer RAM programmed-I/O port.
// Assumes: 16-bit host data bus, byte-addressed 4 kbyte buffer RAM.
// Notes:   Command indices are 7-bit; bit 7 of a command selects write.
package hbp_pkg;
  localparam int          RAM_BYTES      = 4096;
  localparam int          AW             = 12;
  localparam int          DW             = 16;
  localparam int          FIFO_DEPTH     = 4;
  localparam logic [7:0]  CMD_WR_MASK    = 8'h80;
  localparam int          CMD_WR_BIT     = 7;
  localparam logic [6:0]  IDX_ISO_PORT   = 7'h40;
  localparam logic [6:0]  IDX_ACK_PORT   = 7'h41;
  localparam logic [6:0]  IDX_XFER_COUNT = 7'h22;
  localparam logic [6:0]  IDX_INT_STATUS = 7'h24;
  localparam logic [6:0]  IDX_ISO_LEN    = 7'h2A;
  localparam logic [6:0]  IDX_ACK_LEN    = 7'h2B;
  localparam logic [6:0]  IDX_BUF_STATE  = 7'h2C;
  // Interrupt status bit positions.
  localparam int          INT_SVC_BIT    = 1;
  localparam int          INT_EOT_BIT    = 2;
  // Buffer state bit positions.
  localparam int          BS_ISO_A_FULL  = 0;
  localparam int          BS_ISO_B_FULL  = 1;
  localparam int          BS_ACK_FULL    = 2;
  localparam int          BS_ISO_A_DONE  = 3;
  localparam int          BS_ISO_B_DONE  = 4;
  localparam int          BS_ACK_DONE    = 5;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] PTR_STEP       = 16'h0002;
  localparam logic [15:0] ACK_LEN_RESET  = 16'h1000;
  // Frame period; the start-of-frame pulse itself comes from the scheduler.
  localparam int          FRAME_US       = 1;
endpackage

// ==== rtl/hbp_fifo.sv ====
// Purpose: Small write-data FIFO between the host port and the buffer RAM.
// Assumes: Single clock; DEPTH is a power of two.
// Notes:   Ready and empty are honest; the drain side may stall freely.
`timescale 1ns/100ps
module hbp_fifo #(
  parameter int W     = 28,
  parameter int DEPTH = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << PW) != DEPTH)
      $error("hbp_fifo: DEPTH must be a power of two of at least 2");
  end
  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wp_reg;
  logic [PW:0]  rp_reg;
  logic         push;
  logic         pop;

  // Full and empty come from the extra pointer bit, so no separate count.
  assign o_in_ready  = (wp_reg[PW] == rp_reg[PW]) || (wp_reg[PW-1:0] != rp_reg[PW-1:0]);
  assign o_out_valid = wp_reg != rp_reg;
  assign o_out_data  = mem[rp_reg[PW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage has no reset; only the pointers need a defined value.
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wp_reg[PW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule // hbp_fifo

// ==== rtl/hbp_ram.sv ====
// Purpose: Byte-organised buffer RAM with a 16-bit host port.
// Assumes: Host word addresses are even.
// Notes:   Even and odd banks let one word write land in two bytes at once.
`timescale 1ns/100ps
module hbp_ram
  import hbp_pkg::*;
#(
  parameter int BYTES = RAM_BYTES
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata,
  input  wire logic [AW-1:0] i_caddr,
  output logic      [DW-1:0] o_cdata
);
  initial
  begin
    if (BYTES != RAM_BYTES)
      $error("hbp_ram: size must match the address width");
  end
  logic [7:0] even_mem [BYTES/2];
  logic [7:0] odd_mem  [BYTES/2];

  // Low byte to the even location, high byte to the odd one after it.
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      even_mem[i_waddr[AW-1:1]] <= i_wdata[7:0];  // [R04]
      odd_mem[i_waddr[AW-1:1]]  <= i_wdata[15:8]; // [R04]
    end
  end

  // Asynchronous reads; the caller registers the host read result, the controller read goes out unregistered.
  assign o_rdata = {odd_mem[i_raddr[AW-1:1]], even_mem[i_raddr[AW-1:1]]};
  assign o_cdata = {odd_mem[i_caddr[AW-1:1]], even_mem[i_caddr[AW-1:1]]};
endmodule // hbp_ram

// ==== rtl/hbp_port.sv ====
// Purpose: Host command/data port into the controller's buffer RAM.
// Assumes: Host strobes are one-cycle pulses on i_clk; the frame scheduler
//          supplies start-of-frame and list-processed pulses.
// Notes:   Writes pass a small FIFO so a held RAM stalls the host via o_ready.
`timescale 1ns/100ps
// Function
// (R01) Iso port: read 40H, write C0H.
// (R02) Ack port: read 41H, write C1H.
// (R03) Each data access moves two bytes.
// (R04) Low byte even address, high odd.
// (R05) One command, many data accesses.
// (R06) Pointer equals count sets ended flag.
// (R07) End on ack write sets full.
// (R08) Host loads count before streaming.
// (R09) Start of frame swaps iso halves.
// (R10) Both halves full: no swap, second half.
// (R11) Running and processed sets service flag.
// (R12) Running and processed sets ack done.
// (R13) Bus traffic only while running.
// (R14) Large descriptor total splits into packets.
// (R15) Writing bit 2 clears ended flag.
// (R16) Finished iso write sets half full.
// (R17) Iso read clears half full, done.
// (R18) New port command restarts pointer.
// (R19) Bit 7 clear reads, set writes.
module hbp_port
  import hbp_pkg::*;
#(
  parameter int PKT_W = 10
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_wr_stb,
  input  wire logic             i_rd_stb,
  input  wire logic             i_cmd_sel,
  input  wire logic [DW-1:0]    i_wdata,
  output logic      [DW-1:0]    o_rdata,
  output logic                  o_rvalid,
  output logic                  o_ready,
  input  wire logic             i_bus_running,
  input  wire logic             i_sof,
  input  wire logic             i_ack_processed,
  input  wire logic             i_ram_hold,
  input  wire logic [AW-1:0]    i_ctl_addr,
  output logic      [DW-1:0]    o_ctl_data,
  output logic                  o_iso_ctl_half,
  output logic                  o_ack_launch,
  input  wire logic             i_pkt_start,
  input  wire logic             i_pkt_next,
  input  wire logic [PKT_W-1:0] i_pkt_total,
  input  wire logic [PKT_W-1:0] i_pkt_max,
  output logic      [PKT_W-1:0] o_pkt_len,
  output logic                  o_pkt_valid
);
  initial
  begin
    if (PKT_W < 1 || PKT_W > DW)
      $error("hbp_port: PKT_W out of range");
  end

  logic [7:0]       cmd_reg;
  logic [15:0]      ptr_reg;
  logic [15:0]      count_reg;
  logic [15:0]      iso_len_reg;
  logic [15:0]      ack_len_reg;
  logic             eot_flag_reg;
  logic             svc_flag_reg;
  logic             ack_full_reg;
  logic             ack_done_reg;
  logic [1:0]       iso_full_reg;
  logic [1:0]       iso_done_reg;
  logic             host_half_reg;
  logic [PKT_W-1:0] remain_reg;
  logic [15:0]      ptr_next;
  logic [AW-1:0]    byte_addr;
  logic [AW-1:0]    rd_addr;
  logic [DW-1:0]    ram_q;
  logic [AW+DW-1:0] fifo_out;
  logic             fifo_in_ready;
  logic             fifo_valid;
  logic             cmd_wr;
  logic             port_sel;
  logic             is_ack;
  logic             is_write;
  logic             wr_acc;
  logic             rd_acc;
  logic             acc;
  logic             end_of_transfer_event;
  logic             reg_wr;
  logic             half_blocked;

  // A port index, with the direction bit stripped off.
  function automatic logic f_is_port(input logic [7:0] c);
    f_is_port = (c[6:0] == IDX_ISO_PORT) || (c[6:0] == IDX_ACK_PORT); // [R01] [R02]
  endfunction

  // Layout: iso half a, iso half b, then the acknowledged list area.
  function automatic logic [AW-1:0] f_base(input logic ack, input logic half,
                                           input logic [15:0] ilen);
    logic [AW-1:0] l;
    l = {ilen[AW-1:1], 1'b0};
    if (ack)
      f_base = {l[AW-2:0], 1'b0};
    else if (half)
      f_base = l;
    else
      f_base = '0;
  endfunction

  // Command decode; the selection holds until the next command write.
  assign cmd_wr   = i_wr_stb && i_cmd_sel;
  assign port_sel = f_is_port(cmd_reg);                     // [R05]
  assign is_ack   = cmd_reg[0];
  assign is_write = cmd_reg[CMD_WR_BIT];                    // [R19]
  assign half_blocked = !is_ack && iso_full_reg[host_half_reg];
  assign reg_wr   = i_wr_stb && !i_cmd_sel && !port_sel && is_write; // [R19]
  // A write into a half still marked full is dropped without advancing.
  assign wr_acc   = i_wr_stb && !i_cmd_sel && port_sel && is_write
                    && fifo_in_ready && !half_blocked;      // [R16]
  // Reads wait for queued writes so they never see stale bytes.
  assign rd_acc   = i_rd_stb && !i_cmd_sel && port_sel && !is_write && !fifo_valid;
  assign acc      = wr_acc || rd_acc;
  assign ptr_next = ptr_reg + PTR_STEP;                     // [R03]
  assign end_of_transfer_event      = acc && (ptr_next == count_reg);         // [R06] [R08]
  assign byte_addr = f_base(is_ack, host_half_reg, iso_len_reg) + ptr_reg[AW-1:0];
  assign rd_addr  = byte_addr;

  // Host handshake: commands always taken, data waits on the FIFO.
  always_comb
  begin
    if (i_cmd_sel)
      o_ready = 1'b1;
    else if (i_rd_stb && port_sel)
      o_ready = !fifo_valid;
    else if (i_wr_stb && port_sel)
      o_ready = fifo_in_ready;
    else
      o_ready = 1'b1;
  end

  // Current command index.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cmd_reg <= 8'h00;
    else if (cmd_wr)
      cmd_reg <= i_wdata[7:0];                              // [R05]
  end

  // Byte pointer: cleared by any command, stepped by each port word.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ptr_reg <= REG_RESET;
    else if (cmd_wr)
      ptr_reg <= REG_RESET;                                 // [R18]
    else if (acc)
      ptr_reg <= ptr_next;                                  // [R03]
  end

  // Software-written configuration registers.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      count_reg   <= REG_RESET;
      iso_len_reg <= REG_RESET;
      ack_len_reg <= ACK_LEN_RESET;
    end
    else if (reg_wr)
    begin
      if (cmd_reg[6:0] == IDX_XFER_COUNT)
        count_reg <= i_wdata;
      else if (cmd_reg[6:0] == IDX_ISO_LEN)
        iso_len_reg <= i_wdata;
      else if (cmd_reg[6:0] == IDX_ACK_LEN)
        ack_len_reg <= i_wdata;
    end
  end

  // Ended flag: set beats the write-one clear in the same cycle.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      eot_flag_reg <= 1'b0;
    else if (end_of_transfer_event)
      eot_flag_reg <= 1'b1;                                 // [R06]
    else if (reg_wr && cmd_reg[6:0] == IDX_INT_STATUS && i_wdata[INT_EOT_BIT])
      eot_flag_reg <= 1'b0;                                 // [R15]
  end

  // Service flag asks the host to read back the processed list.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      svc_flag_reg <= 1'b0;
    else if (i_ack_processed && i_bus_running && ack_full_reg)
      svc_flag_reg <= 1'b1;                                 // [R11]
    else if (reg_wr && cmd_reg[6:0] == IDX_INT_STATUS && i_wdata[INT_SVC_BIT])
      svc_flag_reg <= 1'b0;
  end

  // Acknowledged list state; reading the list to its end releases it.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_full_reg <= 1'b0;
      ack_done_reg <= 1'b0;
    end
    else
    begin
      if (end_of_transfer_event && is_ack && is_write)
        ack_full_reg <= 1'b1;                               // [R07]
      else if (end_of_transfer_event && is_ack)
        ack_full_reg <= 1'b0;
      if (i_ack_processed && i_bus_running && ack_full_reg)
        ack_done_reg <= 1'b1;                               // [R12]
      else if (end_of_transfer_event && is_ack && !is_write)
        ack_done_reg <= 1'b0;
    end
  end

  // Ping-pong: swap at each frame start unless both halves are full.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      host_half_reg <= 1'b0;
    else if (i_sof && (&iso_full_reg))
      host_half_reg <= 1'b1;                                // [R10]
    else if (i_sof)
      host_half_reg <= !host_half_reg;                      // [R09]
  end

  // Per-half full and done; a done left unread a whole frame expires.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      iso_full_reg <= 2'b00;
      iso_done_reg <= 2'b00;
    end
    else
    begin
      for (int h = 0; h < 2; h++)
      begin
        if (end_of_transfer_event && !is_ack && is_write && host_half_reg == h[0])
          iso_full_reg[h] <= 1'b1;                          // [R16]
        else if ((rd_acc && !is_ack && host_half_reg == h[0])
                 || (i_sof && iso_done_reg[h]))
          iso_full_reg[h] <= 1'b0;                          // [R17]
        if (i_sof && i_bus_running && iso_full_reg[h] && !iso_done_reg[h]
            && host_half_reg != h[0])
          iso_done_reg[h] <= 1'b1;
        else if ((rd_acc && !is_ack && host_half_reg == h[0])
                 || (i_sof && iso_done_reg[h]))
          iso_done_reg[h] <= 1'b0;                          // [R17]
      end
    end
  end

  // Read data for both registers and port words, one cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rdata  <= REG_RESET;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd_stb && !i_cmd_sel && (rd_acc || !port_sel);
      if (rd_acc)
        o_rdata <= ram_q;                                   // [R04]
      else if (i_rd_stb && !i_cmd_sel)
      begin
        if (cmd_reg[6:0] == IDX_XFER_COUNT)
          o_rdata <= count_reg;
        else if (cmd_reg[6:0] == IDX_INT_STATUS)
          o_rdata <= {13'h0000, eot_flag_reg, svc_flag_reg, 1'b0};
        else if (cmd_reg[6:0] == IDX_ISO_LEN)
          o_rdata <= iso_len_reg;
        else if (cmd_reg[6:0] == IDX_ACK_LEN)
          o_rdata <= ack_len_reg;
        else if (cmd_reg[6:0] == IDX_BUF_STATE)
          o_rdata <= {10'h000, ack_done_reg, iso_done_reg, ack_full_reg, iso_full_reg};
        else
          o_rdata <= REG_RESET;
      end
    end
  end

  // Launch the list on the bus only while the controller is running.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ack_launch <= 1'b0;
    else
      o_ack_launch <= i_bus_running && ack_full_reg && !ack_done_reg; // [R13]
  end

  // Packet splitter: a total above the packet size goes out in pieces.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      remain_reg <= '0;
    else if (i_pkt_start)
      remain_reg <= i_pkt_total;                            // [R14]
    else if (i_pkt_next && o_pkt_valid)
      remain_reg <= remain_reg - o_pkt_len;                 // [R14]
  end

  assign o_pkt_len      = (remain_reg > i_pkt_max) ? i_pkt_max : remain_reg;
  assign o_pkt_valid    = i_bus_running && (remain_reg != '0) && (i_pkt_max != '0);
  assign o_iso_ctl_half = !host_half_reg;

  // Write words queue with their byte address; the RAM may hold them off.
  hbp_fifo #(
    .W     (AW + DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (wr_acc),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   ({byte_addr, i_wdata}),
    .o_out_valid (fifo_valid),
    .i_out_ready (!i_ram_hold),
    .o_out_data  (fifo_out)
  );

  hbp_ram u_ram (
    .i_clk   (i_clk),
    .i_we    (fifo_valid && !i_ram_hold),
    .i_waddr (fifo_out[AW+DW-1:DW]),
    .i_wdata (fifo_out[DW-1:0]),
    .i_raddr (rd_addr),
    .o_rdata (ram_q),
    .i_caddr (i_ctl_addr),
    .o_cdata (o_ctl_data)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_ptr_step:   assert property (acc |=> ptr_reg == $past(ptr_reg) + 16'h0002) // [R03]
    else $error("pointer did not step by two");
  a_cmd_clear:  assert property (cmd_wr |=> ptr_reg == 16'h0000) // [R18]
    else $error("pointer not cleared by command");
  a_eot_flag:   assert property (end_of_transfer_event |=> eot_flag_reg) // [R06]
    else $error("ended flag not set");
  a_ack_full:   assert property (end_of_transfer_event && is_ack && is_write |=> ack_full_reg[*2]) // [R07]
    else $error("ack full not set");
  a_sof_swap:   assert property (i_sof && !(&iso_full_reg) // [R09]
                                 |=> host_half_reg != $past(host_half_reg))
    else $error("halves not swapped");
  a_sof_hold:   assert property (i_sof && (&iso_full_reg) |=> host_half_reg) // [R10]
    else $error("host not held on second half");
  a_svc_gate:   assert property (!i_bus_running && !svc_flag_reg |=> !svc_flag_reg) // [R11]
    else $error("service flag set while stopped");
  a_done_gate:  assert property (!i_bus_running && !ack_done_reg |=> !ack_done_reg) // [R12]
    else $error("ack done set while stopped");
  a_w1c_eot:    assert property (reg_wr && cmd_reg[6:0] == IDX_INT_STATUS // [R15]
                                 && i_wdata[INT_EOT_BIT] && !end_of_transfer_event |=> !eot_flag_reg)
    else $error("ended flag not cleared");
  a_no_launch:  assert property (!i_bus_running |=> !o_ack_launch) // [R13]
    else $error("launch while stopped");

  c_ack_eot:    cover property (end_of_transfer_event && is_ack && is_write);
  c_iso_swap:   cover property (i_sof ##1 rd_acc && !is_ack);
  c_fifo_stall: cover property (i_wr_stb && !fifo_in_ready);
  c_split:      cover property (i_pkt_next && o_pkt_valid && remain_reg > i_pkt_max);
endmodule // hbp_port

// ==== test/hbp_host_model.sv ====
// Purpose: Behavioural host processor on the command/data port.
// Assumes: A strobe is taken at a rising edge while i_ready is high.
// Notes:   Idle write data shows the inverse of the last word.
`timescale 1ns/100ps
module hbp_host_model
  import hbp_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_ready,
  input  wire logic          i_rvalid,
  input  wire logic [DW-1:0] i_rdata,
  output logic               o_wr_stb,
  output logic               o_rd_stb,
  output logic               o_cmd_sel,
  output logic      [DW-1:0] o_wdata
);
  int last_wait;

  // The bus starts quiet.
  initial
  begin
    o_wr_stb  = 1'b0;
    o_rd_stb  = 1'b0;
    o_cmd_sel = 1'b0;
    o_wdata   = 16'h0000;
    last_wait = 0;
  end

  // One strobe held to the edge where ready is high, then released.
  task automatic access(input logic wr, input logic sel, input logic [DW-1:0] d);
    @(posedge i_clk);
    o_wr_stb  <= wr;
    o_rd_stb  <= ~wr;
    o_cmd_sel <= sel;
    o_wdata   <= d;
    last_wait = 0;
    // Ready is combinational, so it is judged at the falling edge.
    @(negedge i_clk);
    while (i_ready !== 1'b1 && last_wait < 200)
    begin
      last_wait++;
      @(negedge i_clk);
    end
    @(posedge i_clk);
    o_wr_stb <= 1'b0;
    o_rd_stb <= 1'b0;
    o_wdata  <= ~d;
  endtask

  // A command selects a port or register once for many data accesses.
  task automatic cmd(input logic [7:0] code);
    access(1'b1, 1'b1, {8'h00, code});
  endtask

  task automatic wr(input logic [DW-1:0] d);
    access(1'b1, 1'b0, d);
  endtask

  // Read data is taken in the cycle after the accepted strobe.
  task automatic rd(output logic [DW-1:0] d, output logic v);
    access(1'b0, 1'b0, o_wdata);
    @(negedge i_clk);
    d = i_rdata;
    v = i_rvalid;
  endtask

  // Register writes carry bit 7 set, reads have it clear.
  task automatic reg_write(input logic [6:0] idx, input logic [DW-1:0] val);
    cmd(CMD_WR_MASK | {1'b0, idx});
    wr(val);
  endtask

  task automatic reg_read(input logic [6:0] idx, output logic [DW-1:0] d, output logic v);
    cmd({1'b0, idx});
    rd(d, v);
  endtask
endmodule // hbp_host_model

// ==== test/hbp_port_test.sv ====
// Purpose: Self-checking bench for the buffer RAM host port.
// Assumes: The host model owns the command/data strobes.
// Notes:   Register table rows first, then hand-written sequences.
`timescale 1ns/100ps
module hbp_port_test
  import hbp_pkg::*;
;
  typedef struct {logic [6:0] idx; logic [15:0] rst; logic [15:0] wv; logic [15:0] ex;} hbp_row_t;
  logic          i_clk, i_rst_n, i_bus_running, i_sof, i_ack_processed, i_ram_hold;
  logic          i_pkt_start, i_pkt_next;
  logic [AW-1:0] i_ctl_addr;
  logic [9:0]    i_pkt_total, i_pkt_max, pkt_len;
  logic          wr_stb, rd_stb, cmd_sel, rvalid, ready, iso_half, ack_launch, pkt_valid;
  logic [DW-1:0] wdata, rdata, ctl_data, d;
  logic          v;
  int            miscompares, total_checks, cycles;
  hbp_row_t      rows [6] = '{'{7'h22, 16'h0000, 16'h000A, 16'h000A},
                              '{7'h24, 16'h0000, 16'hFFFF, 16'h0000},
                              '{7'h2A, 16'h0000, 16'h0010, 16'h0010},
                              '{7'h2B, 16'h1000, 16'h0800, 16'h0800},
                              '{7'h2C, 16'h0000, 16'hFFFF, 16'h0000},
                              '{7'h30, 16'h0000, 16'h1234, 16'h0000}};
  logic [15:0]   atl_words [5] = '{16'h0800, 16'h1010, 16'h0810, 16'h0005, 16'h0100};
  logic [9:0]    pkt_exp [3] = '{10'h008, 10'h008, 10'h004};

  hbp_port dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .i_cmd_sel(cmd_sel), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_ready(ready), .i_bus_running(i_bus_running), .i_sof(i_sof),
    .i_ack_processed(i_ack_processed), .i_ram_hold(i_ram_hold), .i_ctl_addr(i_ctl_addr),
    .o_ctl_data(ctl_data), .o_iso_ctl_half(iso_half), .o_ack_launch(ack_launch),
    .i_pkt_start(i_pkt_start), .i_pkt_next(i_pkt_next), .i_pkt_total(i_pkt_total),
    .i_pkt_max(i_pkt_max), .o_pkt_len(pkt_len), .o_pkt_valid(pkt_valid));

  hbp_host_model host (.i_clk(i_clk), .i_ready(ready), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_wr_stb(wr_stb), .o_rd_stb(rd_stb), .o_cmd_sel(cmd_sel), .o_wdata(wdata));

  // Free-running 10 MHz clock.
  initial
  begin
    i_clk = 1'b0;
  end
  always #50 i_clk = ~i_clk;

  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // A register read must answer with a valid pulse as well as the value.
  task automatic rd_reg(input logic [6:0] idx, input logic [15:0] exp);
    host.reg_read(idx, d, v);
    check("register", exp, d);
    check("rvalid", 16'h0001, {15'h0000, v});
  endtask

  task automatic ctl_word(input logic [AW-1:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_ctl_addr <= a;
    @(negedge i_clk);
    check("ctl_data", exp, ctl_data);
  endtask

  task automatic sof_pulse();
    @(posedge i_clk);
    i_sof <= 1'b1;
    @(posedge i_clk);
    i_sof <= 1'b0;
    @(negedge i_clk);
  endtask

  // Main sequence.
  initial
  begin
    i_rst_n         = 1'b0;
    i_bus_running   = 1'b0;
    i_sof           = 1'b0;
    i_ack_processed = 1'b0;
    i_ram_hold      = 1'b0;
    i_pkt_start     = 1'b0;
    i_pkt_next      = 1'b0;
    i_pkt_total     = 10'h000;
    i_ctl_addr      = 12'h000;
    i_pkt_max       = 10'h008;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    foreach (rows[i])
    begin
      rd_reg(rows[i].idx, rows[i].rst);
      host.reg_write(rows[i].idx, rows[i].wv);
      rd_reg(rows[i].idx, rows[i].ex);
    end
    // Acknowledged list write, the FIFO filling under a held RAM.
    @(posedge i_clk);
    i_ram_hold <= 1'b1;
    host.cmd(8'hC1);
    fork
      begin
        repeat (30) @(posedge i_clk);
        i_ram_hold <= 1'b0;
      end
    join_none
    foreach (atl_words[i]) host.wr(atl_words[i]);
    check("fifo_stall", 16'h0001, {15'h0000, host.last_wait > 5});
    foreach (atl_words[i]) ctl_word(AW'(12'h020 + 2 * i), atl_words[i]);
    rd_reg(IDX_INT_STATUS, 16'h0004);
    rd_reg(IDX_BUF_STATE, 16'h0004);
    check("ack_launch", 16'h0000, {15'h0000, ack_launch});
    @(posedge i_clk);
    i_bus_running <= 1'b1;
    repeat (3) @(negedge i_clk);
    check("ack_launch", 16'h0001, {15'h0000, ack_launch});
    @(posedge i_clk);
    i_ack_processed <= 1'b1;
    @(posedge i_clk);
    i_ack_processed <= 1'b0;
    rd_reg(IDX_INT_STATUS, 16'h0006);
    rd_reg(IDX_BUF_STATE, 16'h0024);
    check("ack_launch", 16'h0000, {15'h0000, ack_launch});
    host.reg_write(IDX_INT_STATUS, 16'h0004);
    rd_reg(IDX_INT_STATUS, 16'h0002);
    host.reg_write(IDX_INT_STATUS, 16'h0002);
    // Read back from the start; a new command restarts the pointer.
    host.cmd(8'h41);
    foreach (atl_words[i])
    begin
      host.rd(d, v);
      check("ack_read", atl_words[i], d);
    end
    rd_reg(IDX_BUF_STATE, 16'h0000);
    // Isochronous ping-pong, controller idle so no done flags appear.
    @(posedge i_clk);
    i_bus_running <= 1'b0;
    host.reg_write(IDX_XFER_COUNT, 16'h0004);
    host.cmd(8'hC0);
    host.wr(16'hA1B2);
    host.wr(16'hC3D4);
    rd_reg(IDX_BUF_STATE, 16'h0001);
    sof_pulse();
    check("iso_half", 16'h0000, {15'h0000, iso_half});
    host.cmd(8'hC0);
    host.wr(16'h5566);
    host.wr(16'h7788);
    rd_reg(IDX_BUF_STATE, 16'h0003);
    sof_pulse();
    check("iso_half", 16'h0000, {15'h0000, iso_half});
    // A write into the host half while it is still full must be dropped.
    host.cmd(8'hC0);
    host.wr(16'hDEAD);
    ctl_word(12'h010, 16'h5566);
    host.cmd(8'h40);
    host.rd(d, v);
    check("iso_read", 16'h5566, d);
    rd_reg(IDX_BUF_STATE, 16'h0001);
    ctl_word(12'h000, 16'hA1B2);
    ctl_word(12'h012, 16'h7788);
    // Descriptor total of 20 bytes splits into 8, 8 and 4; packets need a running bus.
    @(posedge i_clk);
    i_bus_running <= 1'b1;
    i_pkt_total <= 10'h014;
    i_pkt_start <= 1'b1;
    @(posedge i_clk);
    i_pkt_start <= 1'b0;
    foreach (pkt_exp[i])
    begin
      @(negedge i_clk);
      check("pkt_len", {6'h00, pkt_exp[i]}, {6'h00, pkt_len});
      check("pkt_valid", 16'h0001, {15'h0000, pkt_valid});
      @(posedge i_clk);
      i_pkt_next <= 1'b1;
      @(posedge i_clk);
      i_pkt_next <= 1'b0;
    end
    @(negedge i_clk);
    check("pkt_valid", 16'h0000, {15'h0000, pkt_valid});
    // Reset in mid-run brings outputs and registers back.
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    check("reset_outs", 16'h0012, {11'h000, ready, rvalid, pkt_valid, iso_half, ack_launch});
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_reg(IDX_ACK_LEN, 16'h1000);
    rd_reg(IDX_XFER_COUNT, 16'h0000);
    print_verdict();
  end
endmodule // hbp_port_test
